// ---- shared/clk_startup_pkg.sv ----
// Purpose: Constants and types for the clock source and start-up selector.
// Assumes: Fuse levels come from a fuse latch on core_clk; register port is plain strobe style.
// Notes: Start-up counts are in cycles of the newly started source, reset delays in watchdog ticks.
package clk_startup_pkg;

	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_TRIM = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;

	localparam logic [3:0] SEL_EXT_CLK = 4'h0;
	localparam logic [3:0] SEL_INT_LO = 4'h1;
	localparam logic [3:0] SEL_INT_HI = 4'h4;
	localparam logic [3:0] SEL_RC_LO = 4'h5;
	localparam logic [3:0] SEL_RC_HI = 4'h8;
	localparam logic [3:0] SEL_DEFAULT = 4'h1;
	localparam logic [1:0] STUP_DEFAULT = 2'h2;
	localparam logic [1:0] STUP_RESERVED = 2'h3;

	localparam logic [16:0] START_RC_LONG = 17'h0_0012;
	localparam logic [16:0] START_SHORT = 17'h0_0006;
	localparam logic [16:0] IRQ_HALT_CYC = 17'h0_0004;
	localparam logic [16:0] RST_NONE_CYC = 17'h0_0000;
	localparam logic [16:0] RST_SHORT_CYC = 17'h0_1000;
	localparam int RST_LONG_CYC_DEF = 32'h0001_0000;

	localparam logic [7:0] RESET_CAL_ADDR = 8'h00;

	typedef enum logic [1:0] {
		SRC_EXT_CLK,
		SRC_INT_RC,
		SRC_EXT_RC,
		SRC_UNSUPPORTED
	} src_t;

	typedef enum logic [2:0] {
		PH_START,
		PH_RSTDLY,
		PH_HALT,
		PH_RUN,
		PH_SLEEP
	} phase_t;

endpackage

// ---- verilog/clock_source_startup_select.sv ----
// Purpose: Decode clock source fuses, time start-up and reset delay, hold the oscillator trim.
// Assumes: src_clk_in and wdt_osc_in are asynchronous and are sampled through two flops.
// Notes: Source and range are latched from the fuses at reset; later fuse changes wait for reset.
`timescale 1ns/1ps

module clock_source_startup_select #(
	parameter int RST_LONG_CYC = clk_startup_pkg::RST_LONG_CYC_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Fuses and straps
	input wire logic [3:0] clock_source_select_fuses,
	input wire logic [1:0] startup_time_fuses,
	input wire logic fuses_blank,
	input wire logic oscillator_option_fuse,
	input wire logic legacy_compat_mode,
	input wire logic [7:0] cal_byte_1mhz,
	// Oscillators
	input wire logic src_clk_in,
	input wire logic wdt_osc_in,
	// Sleep control from the core
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic wake_by_irq,
	// Register port
	input wire logic [clk_startup_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Clock control outputs
	output logic core_clk_en,
	output clk_startup_pkg::src_t clk_src,
	output logic [1:0] freq_range,
	output logic [7:0] trim_value,
	output logic [7:0] cal_addr,
	output logic config_err
);
	import clk_startup_pkg::*;

	typedef struct packed {
		phase_t st;
		logic [16:0] cnt;
		logic from_rst;
		logic irq_wake;
		logic [7:0] trim;
		logic [7:0] rdata;
		logic clk_en;
		src_t src;
		logic [1:0] rng;
		logic [1:0] stup;
		logic [7:0] cal_a;
		logic cfg_err;
		logic [2:0] src_sy;
		logic [2:0] wdt_sy;
	} state_t;

	state_t s_r, s_nxt;
	logic src_edge, wdt_edge;
	logic [16:0] start_tgt, rst_tgt, cnt_inc;
	logic [3:0] sel_eff;
	logic [1:0] stup_eff;
	logic trim_hit;

	// Edges are taken between the second and third flops only
	assign src_edge = s_r.src_sy[1] & ~s_r.src_sy[2];
	assign wdt_edge = s_r.wdt_sy[1] & ~s_r.wdt_sy[2];
	assign cnt_inc = s_r.cnt + 17'h0_0001;
	assign sel_eff = fuses_blank ? SEL_DEFAULT : clock_source_select_fuses;
	assign stup_eff = fuses_blank ? STUP_DEFAULT : startup_time_fuses;
	assign trim_hit = (reg_addr == REG_TRIM) && !legacy_compat_mode;

	// Start-up and reset-delay targets from the latched selection
	always_comb begin
		start_tgt = START_SHORT;
		if (s_r.src == SRC_EXT_RC) begin
			start_tgt = (s_r.stup == STUP_RESERVED) ? START_SHORT : START_RC_LONG;
		end
		unique case (s_r.stup)
			2'h0: rst_tgt = RST_NONE_CYC;
			2'h1: rst_tgt = RST_SHORT_CYC;
			2'h2: rst_tgt = 17'(RST_LONG_CYC);
			// Reserved code on internal RC or external clock falls back to the RST_LONG_CYC delay
			2'h3: rst_tgt = (s_r.src == SRC_EXT_RC) ? RST_SHORT_CYC : 17'(RST_LONG_CYC);
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.src_sy = {s_r.src_sy[1:0], src_clk_in};
		s_nxt.wdt_sy = {s_r.wdt_sy[1:0], wdt_osc_in};
		s_nxt.cal_a = RESET_CAL_ADDR;
		s_nxt.rdata = 8'h00;
		if (reg_rd) begin
			if (trim_hit) begin
				s_nxt.rdata = s_r.trim;
			end else if (reg_addr == REG_STATUS) begin
				s_nxt.rdata = {s_r.cfg_err, s_r.st == PH_RUN, s_r.rng, s_r.stup, s_r.src};
			end
		end
		if (reg_wr && trim_hit) begin
			s_nxt.trim = reg_wdata;
		end
		unique case (s_r.st)
			PH_START: begin
				if (src_edge) begin
					s_nxt.cnt = cnt_inc;
					if (cnt_inc >= start_tgt) begin
						s_nxt.cnt = 17'h0_0000;
						if (s_r.from_rst) begin
							s_nxt.st = (rst_tgt == RST_NONE_CYC) ? PH_RUN : PH_RSTDLY;
						end else begin
							s_nxt.st = s_r.irq_wake ? PH_HALT : PH_RUN;
						end
					end
				end
			end
			PH_RSTDLY: begin
				// Reset time-out counts watchdog oscillator ticks, not the core source
				if (wdt_edge) begin
					s_nxt.cnt = cnt_inc;
					if (cnt_inc >= rst_tgt) begin
						s_nxt.cnt = 17'h0_0000;
						s_nxt.st = PH_RUN;
					end
				end
			end
			PH_HALT: begin
				if (src_edge) begin
					s_nxt.cnt = cnt_inc;
					if (cnt_inc >= IRQ_HALT_CYC) begin
						s_nxt.cnt = 17'h0_0000;
						s_nxt.st = PH_RUN;
					end
				end
			end
			PH_RUN: begin
				if (sleep_req) begin
					s_nxt.st = PH_SLEEP;
				end
			end
			PH_SLEEP: begin
				if (wake_req) begin
					s_nxt.st = PH_START;
					s_nxt.from_rst = 1'b0;
					s_nxt.irq_wake = wake_by_irq;
					s_nxt.cnt = 17'h0_0000;
				end
			end
			default: begin
				s_nxt.st = PH_START;
			end
		endcase
		s_nxt.clk_en = (s_nxt.st == PH_RUN);
		if (reset) begin
			s_nxt.st = PH_START;
			s_nxt.cnt = 17'h0_0000;
			s_nxt.from_rst = 1'b1;
			s_nxt.irq_wake = 1'b0;
			s_nxt.clk_en = 1'b0;
			s_nxt.rdata = 8'h00;
			s_nxt.trim = cal_byte_1mhz;
			s_nxt.stup = stup_eff;
			s_nxt.cfg_err = 1'b0;
			s_nxt.src_sy = 3'h0;
			s_nxt.wdt_sy = 3'h0;
			if (sel_eff == SEL_EXT_CLK) begin
				s_nxt.src = SRC_EXT_CLK;
				s_nxt.rng = 2'h0;
				s_nxt.cfg_err = (stup_eff == STUP_RESERVED);
			end else if (sel_eff <= SEL_INT_HI) begin
				s_nxt.src = SRC_INT_RC;
				s_nxt.rng = 2'(sel_eff - SEL_INT_LO);
				// Option fuse should be left clear with the internal RC
				s_nxt.cfg_err = (stup_eff == STUP_RESERVED) || oscillator_option_fuse;
			end else if (sel_eff <= SEL_RC_HI) begin
				s_nxt.src = SRC_EXT_RC;
				s_nxt.rng = 2'(sel_eff - SEL_RC_LO);
			end else begin
				// Crystal modes are not handled here; report as unsupported, time start-up as external clock and flag it
				s_nxt.src = SRC_UNSUPPORTED;
				s_nxt.rng = 2'h0;
				s_nxt.cfg_err = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		s_r <= s_nxt;
	end

	assign reg_rdata = s_r.rdata;
	assign core_clk_en = s_r.clk_en;
	assign clk_src = s_r.src;
	assign freq_range = s_r.rng;
	assign trim_value = s_r.trim;
	assign cal_addr = s_r.cal_a;
	assign config_err = s_r.cfg_err;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_trim_reset_load;
		$fell(reset) |-> trim_value == $past(cal_byte_1mhz);
	endproperty
	a_trim_reset_load: assert property (p_trim_reset_load) else $error("trim not loaded at reset");

	property p_trim_write;
		reg_wr && reg_addr == REG_TRIM && !legacy_compat_mode |=> trim_value == $past(reg_wdata);
	endproperty
	a_trim_write: assert property (p_trim_write) else $error("trim write lost");

	property p_legacy_absent;
		reg_rd && reg_addr == REG_TRIM && legacy_compat_mode |=> reg_rdata == 8'h00;
	endproperty
	a_legacy_absent: assert property (p_legacy_absent) else $error("trim visible in legacy mode");

	property p_legacy_nowrite;
		reg_wr && legacy_compat_mode && !reg_rd |=> $stable(trim_value);
	endproperty
	a_legacy_nowrite: assert property (p_legacy_nowrite) else $error("trim written in legacy mode");

	property p_ext_rc_select;
		$fell(reset) && !$past(fuses_blank) && $past(clock_source_select_fuses) == SEL_RC_HI
			|-> clk_src == SRC_EXT_RC && freq_range == 2'h3;
	endproperty
	a_ext_rc_select: assert property (p_ext_rc_select) else $error("external RC range wrong");

	property p_default_src;
		$fell(reset) && $past(fuses_blank) |-> clk_src == SRC_INT_RC && freq_range == 2'h0;
	endproperty
	a_default_src: assert property (p_default_src) else $error("blank fuses not default");

	property p_rc_start_len;
		s_r.st == PH_START && s_r.src == SRC_EXT_RC && s_r.stup != STUP_RESERVED
			&& s_r.cnt < START_RC_LONG - 17'h0_0001
			&& src_edge |=> !core_clk_en;
	endproperty
	a_rc_start_len: assert property (p_rc_start_len) else $error("RC start-up too short");

	property p_gate_start;
		s_r.st == PH_START || s_r.st == PH_RSTDLY |-> !core_clk_en;
	endproperty
	a_gate_start: assert property (p_gate_start) else $error("core clock open in start-up");

	property p_halt_four;
		$rose(s_r.st == PH_HALT) |-> !core_clk_en [*4];
	endproperty
	a_halt_four: assert property (p_halt_four) else $error("interrupt halt too short");

	property p_rst_delay_wdt;
		s_r.st == PH_RSTDLY && !wdt_edge |=> $stable(s_r.cnt);
	endproperty
	a_rst_delay_wdt: assert property (p_rst_delay_wdt) else $error("delay not on watchdog ticks");

endmodule // clock_source_startup_select

// ---- tb/osc_model.sv ----
// Purpose: Source and watchdog oscillators facing the selector.
// Assumes: The watchdog is unrelated in phase to core_clk; the source toggles on core_clk falling edges.
// Notes: Fixed periods, so cycle-to-cycle drift is nil.
`timescale 1ns/1ps
module osc_model #(
	parameter real SRC_HALF = 10.0,
	parameter real WDT_HALF = 7.6
) (
	// Oscillator outputs
	output logic src_clk_in,
	output logic wdt_osc_in
);
	initial begin
		src_clk_in = 1'b0;
		wdt_osc_in = 1'b0;
	end
	always #(SRC_HALF) src_clk_in = ~src_clk_in;
	// Separate oscillator keeps the reset delay whatever the source
	always #(WDT_HALF) wdt_osc_in = ~wdt_osc_in;
endmodule // osc_model

// ---- tb/clock_source_startup_select_tb.sv ----
// Purpose: Random and corner checks of fuse decode, start-up timing and trim register.
// Assumes: Source period 4 core cycles, watchdog period 3.04 core cycles.
// Notes: Start-up windows allow for the two-flop sync of both oscillators.
`timescale 1ns/1ps
module clock_source_startup_select_tb;
	import clk_startup_pkg::*;
	localparam int RL = 64;
	logic core_clk = 0, reset = 1, blank = 0, opt = 0, legacy = 0;
	logic sleep_req = 0, wake_req = 0, irq = 0, wr = 0, rd = 0;
	logic [3:0] sel = 0;
	logic [1:0] stup = 0;
	logic [7:0] cal = 0, wdata = 0, rdata, trim, caddr, d, v;
	logic [ADDR_W-1:0] addr = 0;
	logic src_clk, wdt_osc, en, err;
	src_t src;
	logic [1:0] rng;
	int n_errors = 0, total_checks = 0, seed = 85;
	always #2.5 core_clk = ~core_clk;
	osc_model i_osc_model (.src_clk_in(src_clk), .wdt_osc_in(wdt_osc));
	clock_source_startup_select #(.RST_LONG_CYC(RL)) i_clock_source_startup_select (
		.core_clk(core_clk), .reset(reset), .clock_source_select_fuses(sel),
		.startup_time_fuses(stup), .fuses_blank(blank), .oscillator_option_fuse(opt),
		.legacy_compat_mode(legacy), .cal_byte_1mhz(cal), .src_clk_in(src_clk),
		.wdt_osc_in(wdt_osc), .sleep_req(sleep_req), .wake_req(wake_req),
		.wake_by_irq(irq), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .core_clk_en(en), .clk_src(src), .freq_range(rng),
		.trim_value(trim), .cal_addr(caddr), .config_err(err));
	task chk(input string n, input logic [16:0] e, input logic [16:0] s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task wr8(input logic [ADDR_W-1:0] a, input logic [7:0] x);
		@(posedge core_clk);
		wr <= 1;
		addr <= a;
		wdata <= x;
		@(posedge core_clk);
		wr <= 0;
	endtask
	task rd8(input logic [ADDR_W-1:0] a, output logic [7:0] q);
		@(posedge core_clk);
		rd <= 1;
		addr <= a;
		@(posedge core_clk);
		rd <= 0;
		#1 q = rdata;
		@(posedge core_clk);
		#1 chk("rdata_idle", 0, rdata);
	endtask
	// Polls from just after an edge; the window covers sync latency
	task wait_en(input int e, input logic lvl);
		int n;
		n = 0;
		while (en !== lvl && n < e + 16) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk("start_cycles", e, (n > e - 5 && n < e + 16) ? e : n);
	endtask
	function src_t sf(input logic [3:0] s);
		if (s == 0) return SRC_EXT_CLK;
		if (s <= 4) return SRC_INT_RC;
		if (s <= 8) return SRC_EXT_RC;
		return SRC_UNSUPPORTED;
	endfunction
	function int mf(input logic [3:0] s, input logic [1:0] t);
		if (t == 0) return 0;
		if (t == 1 || (t == 3 && sf(s) == SRC_EXT_RC)) return 4096;
		return RL;
	endfunction
	function logic ef(input logic [3:0] s, input logic [1:0] t, input logic o);
		return (t == 3 && sf(s) != SRC_EXT_RC) || sf(s) == SRC_UNSUPPORTED ||
			(o && sf(s) == SRC_INT_RC);
	endfunction
	task run(input logic [3:0] s, input logic [1:0] t, input logic b, input logic o);
		logic [3:0] es;
		logic [1:0] et;
		int nc;
		es = b ? SEL_DEFAULT : s;
		et = b ? STUP_DEFAULT : t;
		nc = (sf(es) == SRC_EXT_RC && et != 3) ? 18 : 6;
		@(posedge core_clk);
		reset <= 1;
		sel <= s;
		stup <= t;
		blank <= b;
		opt <= o;
		cal <= 8'($random(seed));
		repeat (8) @(posedge core_clk);
		#1 chk("trim_reset", cal, trim);
		chk("cal_addr", RESET_CAL_ADDR, caddr);
		chk("src", sf(es), src);
		if (sf(es) == SRC_INT_RC) chk("range", es - 1, rng);
		if (sf(es) == SRC_EXT_RC) chk("range", es - 5, rng);
		chk("cfg_err", ef(es, et, o), err);
		chk("en_reset", 0, en);
		@(posedge core_clk);
		reset <= 0;
		#1 wait_en(nc * 4 + mf(es, et) * 304 / 100, 1);
		rd8(REG_STATUS, d);
		chk("status", {ef(es, et, o), 1'b1, 2'b0, et, sf(es)}, d & 8'hcf);
		rd8(REG_TRIM, d);
		chk("trim_rd", cal, d);
		$display("run select %0h start code %0h done", s, t);
	endtask
	initial begin
		#400000;
		n_errors++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge core_clk);
		run(5, 1, 0, 0);
		run(8, 2, 0, 0);
		run(6, 0, 0, 0);
		run(5, 3, 0, 0);
		run(1, 2, 0, 0);
		run(4, 0, 0, 1);
		run(3, 3, 0, 0);
		run(2, 1, 0, 0);
		run(7, 2, 0, 0);
		run(9, 0, 0, 0);
		run(0, 3, 0, 0);
		run(0, 0, 1, 0);
		run(0, 0, 0, 0);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			wr8(REG_TRIM, v);
			#1 chk("trim_wr", v, trim);
			rd8(REG_TRIM, d);
			chk("trim_rd", v, d);
		end
		wr8(4'hf, ~v);
		#1 chk("trim_unmapped", v, trim);
		rd8(4'hf, d);
		chk("unmapped_rd", 0, d);
		@(posedge core_clk);
		legacy <= 1;
		wr8(REG_TRIM, ~v);
		#1 chk("trim_legacy", v, trim);
		rd8(REG_TRIM, d);
		chk("legacy_rd", 0, d);
		$display("register test done");
		@(posedge core_clk);
		legacy <= 0;
		wake_req <= 1;
		@(posedge core_clk);
		wake_req <= 0;
		repeat (3) @(posedge core_clk);
		#1 chk("wake_in_run", 1, en);
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			sleep_req <= 1;
			@(posedge core_clk);
			sleep_req <= 0;
			#1 wait_en(1, 0);
			@(posedge core_clk);
			wake_req <= 1;
			irq <= (i == 0);
			@(posedge core_clk);
			wake_req <= 0;
			#1 wait_en((i == 0) ? 40 : 24, 1);
			$display("wake test %0d done", i);
		end
		end_of_test;
	end
endmodule // clock_source_startup_select_tb
